// [pkg/multidrop_consts.vh]
// Purpose: constants for the multidrop control block
// Assumes: 32-bit register word, full 32-bit byte addresses into the peripheral map
// Notes: register offsets are full byte addresses of the peripheral map
`ifndef MULTIDROP_CONSTS_VH
`define MULTIDROP_CONSTS_VH
`define ADDR_W 32
`define DATA_W 32
`define MATCH_W 8
`define OFS_MULTIDROP_CONTROL 32'h4000804C
`define OFS_STATION_ADDRESS_MATCH 32'h40008050
`define BIT_MULTIDROP_EN 0
`define BIT_RX_DISABLE 1
`define BIT_AUTO_ADDR_EN 2
`define BIT_DIR_PIN_SEL 3
`define BIT_DIR_CTRL_EN 4
`define BIT_DIR_INVERT 5
`define CTRL_W 6
`define CTRL_RESET 6'h00
`define MATCH_RESET 8'h00
`define PIN_IDLE 1'b1
`endif

// [logic/uart_rs485_multidrop_control.v]
// Purpose: multidrop control, address match and direction control
// Assumes: receive and transmit events come from uart logic on clk_in
// Notes: outputs are registered; rx and read outputs follow their cause by one cycle, pins follow tx write/done by two
// Notes on behaviour
// - multidrop enable, auto mode off: address byte flags parity error and interrupt
// - receiver disable bit: 0 enabled, 1 disabled, resets to 0
// - auto address detect enable bit at position 2, resets to 0
// - pin select bit 3: 0 routes direction to rts, 1 to dtr
// - direction control enable turns automatic direction control on
// - polarity 0: pin low while data pending, high after last bit
// - polarity 1: pin high while data pending, low after last bit
// - match register holds 8-bit station address, reset 0x00
// - direction enable at bit 4, polarity invert at bit 5
// - multidrop, auto mode off, receiver disabled: drop data, store address and flag
// - auto mode match: store with ninth bit, clear disable, flag
// - auto mode mismatch while enabled: set disable, do not store
`timescale 1ns/10ps
`include "multidrop_consts.vh"
module uart_rs485_multidrop_control (
  input wire clk_in,
  input wire sys_rst_in,
  input wire bus_sel_in,
  input wire bus_write_in,
  input wire [`ADDR_W-1:0] bus_addr_in,
  input wire [31:0] bus_wdata_in,
  output reg [31:0] bus_rdata_out,
  input wire rx_byte_valid_in,
  input wire [7:0] rx_byte_in,
  input wire rx_ninth_in,
  output reg rx_push_out,
  output reg [8:0] rx_push_data_out,
  output reg rx_ready_irq_out,
  output reg parity_error_out,
  input wire tx_write_in,
  input wire tx_done_in,
  input wire rts_modem_in,
  input wire dtr_modem_in,
  output reg rts_pin_out,
  output reg dtr_pin_out
);

  reg [`CTRL_W-1:0] ctrl_q;
  reg [7:0] match_q;
  reg tx_busy_q;
  reg [`CTRL_W-1:0] ctrl_d;
  reg push_d;
  reg irq_d;
  reg perr_d;
  reg dir_level;
  wire wr_ctrl;
  wire wr_match;
  wire multidrop;
  wire auto_mode;
  wire is_addr;
  wire addr_hit;
  wire rts_dir;
  wire dtr_dir;

  // exact full-address match; anything else on the bus is ignored
  function reg_hit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] ofs;
    begin
      reg_hit = (addr == ofs);
    end
  endfunction

  // reserved bits read as zero so software never sees stale state
  function [`DATA_W-1:0] read_word;
    input [`ADDR_W-1:0] addr;
    input [`CTRL_W-1:0] ctrl;
    input [`MATCH_W-1:0] match;
    begin
      if (reg_hit(addr, `OFS_MULTIDROP_CONTROL)) begin
        read_word = {{(`DATA_W-`CTRL_W){1'b0}}, ctrl};
      end else if (reg_hit(addr, `OFS_STATION_ADDRESS_MATCH)) begin
        read_word = {{(`DATA_W-`MATCH_W){1'b0}}, match};
      end else begin
        read_word = {`DATA_W{1'b0}};
      end
    end
  endfunction

  // active level is low unless inverted
  function dir_drive;
    input busy;
    input invert;
    begin
      dir_drive = busy ? invert : ~invert;
    end
  endfunction

  // the chosen pin follows direction, the other keeps its modem level
  function pin_level;
    input use_dir;
    input dir;
    input modem;
    begin
      pin_level = use_dir ? dir : modem;
    end
  endfunction

  assign wr_ctrl = bus_sel_in & bus_write_in &
    reg_hit(bus_addr_in, `OFS_MULTIDROP_CONTROL);
  assign wr_match = bus_sel_in & bus_write_in &
    reg_hit(bus_addr_in, `OFS_STATION_ADDRESS_MATCH);
  assign multidrop = ctrl_q[`BIT_MULTIDROP_EN];
  // comparing needs both enables; auto bit alone does nothing
  assign auto_mode = multidrop & ctrl_q[`BIT_AUTO_ADDR_EN];
  assign rts_dir = ctrl_q[`BIT_DIR_CTRL_EN] & ~ctrl_q[`BIT_DIR_PIN_SEL];
  assign dtr_dir = ctrl_q[`BIT_DIR_CTRL_EN] & ctrl_q[`BIT_DIR_PIN_SEL];
  assign is_addr = rx_byte_valid_in & rx_ninth_in;
  assign addr_hit = (rx_byte_in == match_q);

  always @* begin
    ctrl_d = ctrl_q;
    push_d = 1'b0;
    irq_d = 1'b0;
    perr_d = 1'b0;
    if (wr_ctrl) begin
      ctrl_d = bus_wdata_in[`CTRL_W-1:0];
    end
    if (rx_byte_valid_in) begin
      if (!multidrop) begin
        push_d = ~ctrl_q[`BIT_RX_DISABLE];
        irq_d = push_d;
      end else if (auto_mode) begin
        if (is_addr && addr_hit) begin
          push_d = 1'b1;
          irq_d = 1'b1;
          // hardware clear wins over a same-cycle software write
          ctrl_d[`BIT_RX_DISABLE] = 1'b0;
        end else if (is_addr) begin
          ctrl_d[`BIT_RX_DISABLE] = 1'b1;
        end else begin
          push_d = ~ctrl_q[`BIT_RX_DISABLE];
          irq_d = push_d;
        end
      end else begin
        if (is_addr) begin
          push_d = 1'b1;
          irq_d = 1'b1;
          perr_d = 1'b1;
        end else begin
          push_d = ~ctrl_q[`BIT_RX_DISABLE];
          irq_d = push_d;
        end
      end
    end
    dir_level = dir_drive(tx_busy_q, ctrl_q[`BIT_DIR_INVERT]);
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctrl_q <= `CTRL_RESET;
      match_q <= `MATCH_RESET;
      bus_rdata_out <= {`DATA_W{1'b0}};
    end else begin
      ctrl_q <= ctrl_d;
      if (wr_match) begin
        match_q <= bus_wdata_in[`MATCH_W-1:0];
      end
      // read data is registered, so it trails the address by one cycle
      bus_rdata_out <= read_word(bus_addr_in, ctrl_q, match_q);
    end
  end

  // a new write keeps the pin asserted even as the last byte ends
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      tx_busy_q <= 1'b0;
    end else if (tx_write_in) begin
      tx_busy_q <= 1'b1;
    end else if (tx_done_in) begin
      tx_busy_q <= 1'b0;
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_push_out <= 1'b0;
      rx_push_data_out <= 9'h000;
      rx_ready_irq_out <= 1'b0;
      parity_error_out <= 1'b0;
    end else begin
      rx_push_out <= push_d;
      // ninth bit travels with the byte so software can tell addresses
      rx_push_data_out <= {rx_ninth_in, rx_byte_in};
      rx_ready_irq_out <= irq_d;
      parity_error_out <= perr_d;
    end
  end

  // direction takes precedence over modem control on the selected pin
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      rts_pin_out <= `PIN_IDLE;
      dtr_pin_out <= `PIN_IDLE;
    end else begin
      rts_pin_out <= pin_level(rts_dir, dir_level, rts_modem_in);
      dtr_pin_out <= pin_level(dtr_dir, dir_level, dtr_modem_in);
    end
  end

endmodule // uart_rs485_multidrop_control

// [verification/multidrop_monitor.sv]
// Purpose: port checker. Assumes: shadows see software writes only.
// Notes: bit 1 is masked, hardware may flip it in auto mode
`timescale 1ns/10ps
module multidrop_monitor (
  input wire clk_in, sys_rst_in, bus_sel_in, bus_write_in, rx_byte_valid_in,
  input wire rx_ninth_in, rx_push_out, rx_ready_irq_out, parity_error_out,
  input wire tx_write_in, tx_done_in, rts_pin_out, dtr_pin_out,
  input wire [31:0] bus_addr_in, bus_wdata_in, bus_rdata_out,
  input wire [7:0] rx_byte_in,
  input wire [8:0] rx_push_data_out
);
  reg [5:0] c_q;
  reg [7:0] m_q;
  wire w = bus_sel_in & bus_write_in;
  wire adr = rx_byte_valid_in & rx_ninth_in & c_q[0];
  wire pin = c_q[3] ? dtr_pin_out : rts_pin_out;
  always @(posedge clk_in)
    if (sys_rst_in) c_q <= 6'h00;
    else if (w && bus_addr_in == 32'h4000804C) c_q <= bus_wdata_in[5:0];
  always @(posedge clk_in)
    if (sys_rst_in) m_q <= 8'h00;
    else if (w && bus_addr_in == 32'h40008050) m_q <= bus_wdata_in[7:0];
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_tx; tx_write_in ##1 c_q[4]; endsequence
  sequence s_end; tx_done_in && !tx_write_in ##1 c_q[4] && !tx_write_in; endsequence
  property p_on; s_tx |=> pin == c_q[5]; endproperty
  a_on: assert property (p_on) else $error("pin not driven");
  property p_off; s_end |=> pin != c_q[5]; endproperty
  a_off: assert property (p_off) else $error("pin not released");
  property p_rdc; $past(bus_addr_in) == 32'h4000804C |->
    (bus_rdata_out & 32'hFFFFFFFD) == {26'h0, $past(c_q) & 6'h3D}; endproperty
  a_rdc: assert property (p_rdc) else $error("ctrl read");
  property p_rdm; $past(bus_addr_in) == 32'h40008050 |->
    bus_rdata_out == {24'h0, $past(m_q)}; endproperty
  a_rdm: assert property (p_rdm) else $error("match read");
  property p_par; adr && !c_q[2] |=> parity_error_out; endproperty
  a_par: assert property (p_par) else $error("no parity flag");
  property p_hit; adr && c_q[2] && rx_byte_in == m_q |=>
    rx_push_out && rx_ready_irq_out; endproperty
  a_hit: assert property (p_hit) else $error("match lost");
  property p_miss; adr && c_q[2] && rx_byte_in != m_q |=> !rx_push_out; endproperty
  a_miss: assert property (p_miss) else $error("mismatch kept");
  property p_push; rx_push_out |-> $past(rx_byte_valid_in) &&
    rx_push_data_out == {$past(rx_ninth_in), $past(rx_byte_in)}; endproperty
  a_push: assert property (p_push) else $error("push data");
endmodule // multidrop_monitor

// [verification/rs485_peer.sv]
// Purpose: far side. Assumes: 12 cycle frames. Notes: idle byte inverted
`timescale 1ns/10ps
module rs485_peer (
  input wire clk_in, tx_write_in,
  output reg rx_byte_valid_in = 1'b0, rx_ninth_in = 1'b0, tx_done_in = 1'b0,
  output reg [7:0] rx_byte_in = 8'h00
);
  integer n = 0;
  always @(negedge clk_in) begin
    tx_done_in <= n == 1;
    n <= tx_write_in ? 12 : n - (n > 0);
  end
  task send(input [7:0] x, input p);
    begin
      rx_byte_in <= x;
      rx_ninth_in <= p;
      rx_byte_valid_in <= 1'b1;
      @(negedge clk_in);
      rx_byte_valid_in <= 1'b0;
      rx_byte_in <= ~x;
    end
  endtask
endmodule // rs485_peer

// [verification/uart_rs485_multidrop_control_tb_top.sv]
// Purpose: bench. Assumes: peer frames of 12 cycles. Notes: queue of pushes
`timescale 1ns/10ps
module uart_rs485_multidrop_control_tb_top;
  reg clk_in = 1'b0, sys_rst_in = 1'b1, bus_sel_in = 1'b0, bus_write_in = 1'b0;
  reg tx_write_in = 1'b0, rts_modem_in = 1'b0, dtr_modem_in = 1'b0;
  reg [31:0] bus_addr_in = 32'h0, bus_wdata_in = 32'h0;
  reg [7:0] m;
  wire [31:0] bus_rdata_out;
  wire rx_byte_valid_in, rx_ninth_in, tx_done_in, rx_push_out, rx_ready_irq_out;
  wire parity_error_out, rts_pin_out, dtr_pin_out;
  wire [7:0] rx_byte_in;
  wire [8:0] rx_push_data_out;
  integer error_cnt = 0, checks = 0, c = 0, pe = 0, pg = 0, i, q[$];
  always #10 clk_in = ~clk_in;
  uart_rs485_multidrop_control dut_u (.*);
  rs485_peer peer_u (.*);
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task acc(input w, input [31:0] a, input [31:0] d);
    begin
      @(negedge clk_in);
      {bus_sel_in, bus_write_in, bus_addr_in, bus_wdata_in} <= {1'b1, w, a, d};
      @(negedge clk_in);
      bus_sel_in <= 1'b0;
    end
  endtask
  task rx(input [7:0] x, input p);
    begin
      if (c[0] && p && !c[2]) pe = pe + 1;
      if (c[0] && c[2] && p) c[1] = x != m;
      if (c[0] && c[2] && p ? x == m : !c[1] || c[0] && p) q.push_back({p, x});
      peer_u.send(x, p);
      repeat (3) @(negedge clk_in);
    end
  endtask
  task pins(input act);
    reg [1:0] e;
    begin
      e = {dtr_modem_in, rts_modem_in};
      if (c[4]) e[c[3]] = act ^ !c[5];
      chk({dtr_pin_out, rts_pin_out}, e);
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  always @(negedge clk_in) begin
    pg = pg + parity_error_out;
    chk(rx_ready_irq_out, rx_push_out);
    if (rx_push_out) chk(rx_push_data_out, q.size() ? q.pop_front() : -1);
  end
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    results;
  end
  initial begin
    i = $urandom(32'h32D4);
    m = $urandom;
    {rts_modem_in, dtr_modem_in} = $urandom;
    repeat (16) @(negedge clk_in);
    sys_rst_in <= 1'b0;
    for (i = 0; i < 3; i = i + 1) begin
      acc(1'b0, 32'h4000804C + 4 * i, 32'h0);
      chk(bus_rdata_out, 32'h0);
    end
    acc(1'b1, 32'h40008050, $urandom << 8 | m);
    acc(1'b0, 32'h40008050, 32'h0);
    chk(bus_rdata_out, m);
    $display("reset and match done");
    for (i = 0; i < 5; i = i + 1) begin
      c = 20'h75310 >> 4 * i & 7;
      acc(1'b1, 32'h4000804C, c);
      rx(m ^ 8'h01, 1'b1);
      rx($urandom, 1'b0);
      rx(m, 1'b1);
      rx($urandom, 1'b0);
      acc(1'b0, 32'h4000804C, 32'h0);
      chk(bus_rdata_out, c);
      pins(1'b0);
      $display("receive mode %0d done", i);
    end
    for (i = 0; i < 4; i = i + 1) begin
      c = 16 | (i & 1) << 3 | (i & 2) << 4;
      acc(1'b1, 32'h4000804C, c);
      tx_write_in <= 1'b1;
      @(negedge clk_in);
      tx_write_in <= 1'b0;
      repeat (2) @(negedge clk_in);
      pins(1'b1);
      repeat (16) @(negedge clk_in);
      pins(1'b0);
      $display("direction case %0d done", i);
    end
    chk(pg, pe);
    chk(q.size(), 0);
    results;
  end
endmodule // uart_rs485_multidrop_control_tb_top
bind uart_rs485_multidrop_control multidrop_monitor mon_u (.*);
